//--- hdl/sfp_page_buf.sv
`timescale 1ns/10ps
module sfp_page_buf #(
   parameter int DEPTH = 512,
   parameter int IW    = 9
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // fill side
   input  wire logic          clr,
   input  wire logic          we,
   input  wire logic [IW-1:0] widx,
   input  wire logic [7:0]    wdata,
   // drain side, one cycle latency
   input  wire logic [IW-1:0] ridx,
   output logic      [7:0]    rdata,
   output logic               rvalid
);
   logic [7:0]       mem [DEPTH];
   logic [DEPTH-1:0] valid_r;

   // valid marks which offsets hold loaded bytes; untouched ones stay unchanged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_r <= '0;
         rvalid  <= 1'b0;
      end else begin
         if (clr) begin
            valid_r <= '0;
         end else if (we) begin
            valid_r[widx] <= 1'b1;
         end
         rvalid <= valid_r[ridx];
      end
   end

   // data needs no reset, valid guards it
   always_ff @(posedge clk) begin
      if (we) begin
         mem[widx] <= wdata;
      end
      rdata <= mem[ridx];
   end
endmodule : sfp_page_buf

//--- hdl/sfp_pkg.sv
package sfp_pkg;
   // array geometry
   localparam int AW      = 25;            // byte address width
   localparam int PIW     = 9;             // page offset width
   localparam int BLK_SH  = 12;            // 4-kB block
   localparam int SEC_SH  = 16;            // 64-kB physical sector
   localparam int OVL_SH  = 15;            // 32-kB parameter overlay
   localparam int BW      = AW - BLK_SH;   // block number width
   localparam int SW      = AW - SEC_SH;   // sector number width
   localparam int PW      = OVL_SH - BLK_SH;
   localparam int NSEC    = 1 << SW;
   localparam int NPAR    = 1 << PW;
   localparam int TW      = 16;            // op timer width

   localparam logic [PIW-1:0] PMASK_S  = 9'h0FF;
   localparam logic [PIW-1:0] PMASK_L  = 9'h1FF;
   localparam logic [BW-1:0]  BLKS_64  = 13'h000F;
   localparam logic [BW-1:0]  BLKS_256 = 13'h003F;
   localparam logic [3:0]     BYTE_BITS = 4'h8;
   localparam logic [3:0]     STEP_SER  = 4'h1;
   localparam logic [3:0]     STEP_QUAD = 4'h4;
   localparam logic [2:0]     ALEN3     = 3'h3;
   localparam logic [2:0]     ALEN4     = 3'h4;
   localparam logic [5:0]     LINK_IDLE = 6'h10;   // chip select high

   // instruction codes
   localparam logic [7:0] CMD_WRITE_ENABLE_CMD     = 8'h06;
   localparam logic [7:0] CMD_PROG     = 8'h02;
   localparam logic [7:0] CMD_PROG_W   = 8'h12;
   localparam logic [7:0] CMD_PERASE   = 8'h20;
   localparam logic [7:0] CMD_PERASE_W = 8'h21;
   localparam logic [7:0] CMD_SERASE   = 8'hD8;
   localparam logic [7:0] CMD_SERASE_W = 8'hDC;

   // internal cycle times
   localparam int SYS_PERIOD_NS = 10;
   localparam int PROG_TIME_NS  = 2000;
   localparam int ERASE_TIME_NS = 8000;
   localparam int PROG_CYC  = (PROG_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   typedef struct packed {
      logic       sck;
      logic       cs_n;
      logic [3:0] io;
   } sfp_link_t;

   typedef struct packed {
      logic addr4;      // address-length bit
      logic quad;       // quad command mode
      logic page512;    // page-size bit
      logic uniform;    // sector-layout bit
      logic param_top;  // overlay at top of map
      logic sect256;    // erase-size bit
   } sfp_cfg_t;

   typedef struct packed {
      logic          wr;
      logic          param;
      logic [SW-1:0] idx;
      logic          persistent_protect_bit;
      logic          dynamic_protect_bit;
   } sfp_prot_t;

   typedef struct packed {
      logic write_in_progress;
      logic write_enable_latch;
      logic p_err;
      logic e_err;
   } sfp_status_t;

   typedef struct packed {
      logic          wr;
      logic          erase;
      logic [AW-1:0] addr;
      logic [7:0]    data;
   } sfp_arr_t;
endpackage : sfp_pkg

//--- hdl/sfp_seq.sv
`timescale 1ns/10ps
module sfp_seq #(
   parameter int PROG_CYCLES  = sfp_pkg::PROG_CYC,
   parameter int ERASE_CYCLES = sfp_pkg::ERASE_CYC
) (
   // clock and reset
   input  wire logic                 SYS_CLK,
   input  wire logic                 RSTN,
   // serial link pins, asynchronous
   input  wire sfp_pkg::sfp_link_t   LINK,
   // configuration and protection
   input  wire sfp_pkg::sfp_cfg_t    CFG,
   input  wire logic [2:0]           BP,
   input  wire sfp_pkg::sfp_prot_t   PROT,
   // status
   input  wire logic                 CLR_ERR,
   output sfp_pkg::sfp_status_t      STATUS,
   // flash array port
   output sfp_pkg::sfp_arr_t         ARR
);
   import sfp_pkg::*;

   typedef enum logic [2:0] {F_IDLE, F_CMD, F_ADDR, F_DATA, F_SKIP} sfp_frame_t;
   typedef enum logic [1:0] {K_PROG, K_PERASE, K_SERASE} sfp_kind_t;
   typedef enum logic [1:0] {O_IDLE, O_CHECK, O_RUN, O_WAIT} sfp_op_t;

   sfp_frame_t      frame_r;
   sfp_kind_t       kind_r, okind_r;
   sfp_op_t         op_r;
   logic [7:0]      shift_r;
   logic [3:0]      bcnt_r;
   logic [2:0]      abytes_r;
   logic [31:0]     addr_r;
   logic [PIW-1:0]  ptr_r, idx_r, pidx_r;
   logic            got_r, wel_r, hit_r, pact_r, perr_r, eerr_r;
   logic [BW-1:0]   blk_r, blk0_r, blk_end_r;
   logic [AW-1:0]   base_r;
   logic [TW-1:0]   tmr_r;
   logic [NSEC-1:0] ppb_r, dyb_r;
   logic [NPAR-1:0] pppb_r, pdyb_r;
   sfp_arr_t        arr_r;
   sfp_link_t       lvl_s, rise_s, fall_s;
   logic [7:0]      buf_rdata;
   logic            buf_rvalid;

   // pins pass four flops before any use
   sfp_sync #(.W(6), .INIT(LINK_IDLE)) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RSTN),
      .din   (LINK),
      .lvl   (lvl_s),
      .rise  (rise_s),
      .fall  (fall_s)
   );

   // block lies in the parameter overlay
   function automatic logic in_ovl(input logic [BW-1:0] b, input logic top);
      in_ovl = top ? (&b[BW-1:PW]) : ~(|b[BW-1:PW]);
   endfunction : in_ovl

   // block protection: top 1/2^(7-BP) of sectors, none when BP is zero
   localparam logic [2:0] BP_ALL_F = 3'h7;
   function automatic logic bp_prot(input logic [SW-1:0] s, input logic [2:0] bp);
      logic [3:0] k;
      k = {1'b0, BP_ALL_F} - {1'b0, bp};
      bp_prot = (bp != 3'h0) && ((~s >> (4'(SW) - k)) == '0);
   endfunction : bp_prot

   // serial bit assembly
   wire             ev_bit    = rise_s.sck & ~lvl_s.cs_n;
   wire  [3:0]      step      = CFG.quad ? STEP_QUAD : STEP_SER;
   wire  [3:0]      bcnt_nxt  = bcnt_r + step;
   wire             live      = (frame_r != F_IDLE) && (frame_r != F_SKIP);
   wire             overrun   = (frame_r == F_ADDR) && (abytes_r == 3'h0);
   wire             byte_fin  = ev_bit & live & ~overrun & (bcnt_nxt == BYTE_BITS);
   wire  [7:0]      shift_nxt = CFG.quad ? {shift_r[3:0], lvl_s.io} : {shift_r[6:0], lvl_s.io[0]};
   wire  [31:0]     addr_nxt  = {addr_r[23:0], shift_nxt};
   wire  [PIW-1:0]  pmask     = CFG.page512 ? PMASK_L : PMASK_S;

   // instruction decode
   wire is_write_enable_cmd = shift_nxt == CMD_WRITE_ENABLE_CMD;
   wire is_prog = (shift_nxt == CMD_PROG) || (shift_nxt == CMD_PROG_W);
   wire is_pe   = (shift_nxt == CMD_PERASE) || (shift_nxt == CMD_PERASE_W);
   wire is_se   = (shift_nxt == CMD_SERASE) || (shift_nxt == CMD_SERASE_W);
   wire wide    = (shift_nxt == CMD_PROG_W) || (shift_nxt == CMD_PERASE_W) || (shift_nxt == CMD_SERASE_W);
   wire busy    = op_r != O_IDLE;
   wire in_cmd  = byte_fin && (frame_r == F_CMD);
   wire accept  = in_cmd & wel_r & ~busy & (is_prog | is_se | (is_pe & ~CFG.uniform));
   wire [2:0] alen = (wide | CFG.addr4) ? ALEN4 : ALEN3;

   // page buffer strobes
   wire last_ab = byte_fin && (frame_r == F_ADDR) && (abytes_r == 3'h1);
   wire buf_clr = last_ab && (kind_r == K_PROG);
   wire buf_we  = byte_fin && (frame_r == F_DATA);

   // start on chip-select rise only at a byte boundary after the address
   wire [BW-1:0] cblk = addr_r[AW-1:BLK_SH];
   wire erase_rdy   = overrun && (bcnt_r == 4'h0) && (kind_r != K_PROG);
   wire start_erase = rise_s.cs_n & erase_rdy;
   wire start_prog  = rise_s.cs_n && (frame_r == F_DATA) && got_r && (bcnt_r == 4'h0);
   wire pe_large    = (kind_r == K_PERASE) && !in_ovl(cblk, CFG.param_top);
   wire start       = start_prog | (start_erase & ~pe_large);
   wire [BW-1:0] smask  = (kind_r != K_SERASE) ? '0 : (CFG.sect256 ? BLKS_256 : BLKS_64);
   wire [BW-1:0] sfirst = cblk & ~smask;

   // protection of one 4-kB block, overlay sectors have their own bits
   wire [SW-1:0] sec    = blk_r[BW-1 -: SW];
   wire          b_ovl  = in_ovl(blk_r, CFG.param_top) & ~CFG.uniform;
   wire          p_prot = pppb_r[blk_r[PW-1:0]] | pdyb_r[blk_r[PW-1:0]];
   wire          s_prot = ppb_r[sec] | dyb_r[sec];
   wire          blk_prot = bp_prot(sec, BP) | (b_ovl ? p_prot : s_prot);
   wire          chk_end  = (op_r == O_CHECK) && (blk_r == blk_end_r);
   wire          chk_fail = chk_end & (hit_r | blk_prot);
   wire          run_end  = (op_r == O_RUN) && ((okind_r == K_PROG) ? (idx_r == pmask) : (blk_r == blk_end_r));
   wire          op_done  = ((op_r == O_WAIT) && (tmr_r == '0)) | chk_fail;

   // command framing
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         frame_r  <= F_IDLE;
         kind_r   <= K_PROG;
         shift_r  <= '0;
         bcnt_r   <= '0;
         abytes_r <= '0;
         addr_r   <= '0;
         ptr_r    <= '0;
         got_r    <= 1'b0;
      end else if (fall_s.cs_n) begin
         frame_r <= F_CMD;
         bcnt_r  <= '0;
      end else if (rise_s.cs_n) begin
         frame_r <= F_IDLE;
      end else if (ev_bit && live) begin
         if (overrun) begin
            frame_r <= F_SKIP;
         end else begin
            shift_r <= shift_nxt;
            bcnt_r  <= byte_fin ? 4'h0 : bcnt_nxt;
         end
         if (in_cmd) begin
            frame_r  <= accept ? F_ADDR : F_SKIP;
            kind_r   <= is_prog ? K_PROG : (is_pe ? K_PERASE : K_SERASE);
            abytes_r <= alen;
            addr_r   <= '0;
         end else if (byte_fin && frame_r == F_ADDR) begin
            addr_r   <= addr_nxt;
            abytes_r <= abytes_r - 3'h1;
            if (buf_clr) begin
               frame_r <= F_DATA;
               ptr_r   <= addr_nxt[PIW-1:0] & pmask;
               got_r   <= 1'b0;
            end
         end else if (buf_we) begin
            ptr_r <= (ptr_r + 9'h001) & pmask;
            got_r <= 1'b1;
         end
      end
   end

   // page buffer, one page deep
   sfp_page_buf #(.DEPTH(1 << PIW), .IW(PIW)) u_buf (
      .clk    (SYS_CLK),
      .rst_n  (RSTN),
      .clr    (buf_clr),
      .we     (buf_we),
      .widx   (ptr_r),
      .wdata  (shift_nxt),
      .ridx   (idx_r),
      .rdata  (buf_rdata),
      .rvalid (buf_rvalid)
   );

   // latch and error flags; a set beats a same-cycle clear
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wel_r  <= 1'b0;
         perr_r <= 1'b0;
         eerr_r <= 1'b0;
      end else begin
         if (in_cmd && is_write_enable_cmd && !busy) begin
            wel_r <= 1'b1;
         end else if (op_done) begin
            wel_r <= 1'b0;
         end
         perr_r <= (chk_fail && okind_r == K_PROG) | (perr_r & ~CLR_ERR);
         eerr_r <= (chk_fail && okind_r != K_PROG) | (eerr_r & ~CLR_ERR);
      end
   end

   // protection bits, volatile copy loaded from outside
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ppb_r  <= '0;
         dyb_r  <= '0;
         pppb_r <= '0;
         pdyb_r <= '0;
      end else if (PROT.wr && PROT.param) begin
         pppb_r[PROT.idx[PW-1:0]] <= PROT.persistent_protect_bit;
         pdyb_r[PROT.idx[PW-1:0]] <= PROT.dynamic_protect_bit;
      end else if (PROT.wr) begin
         ppb_r[PROT.idx] <= PROT.persistent_protect_bit;
         dyb_r[PROT.idx] <= PROT.dynamic_protect_bit;
      end
   end

   // internal operation: check whole range, then act, then wait
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         op_r      <= O_IDLE;
         okind_r   <= K_PROG;
         blk_r     <= '0;
         blk0_r    <= '0;
         blk_end_r <= '0;
         hit_r     <= 1'b0;
         idx_r     <= '0;
         base_r    <= '0;
         tmr_r     <= '0;
      end else begin
         unique case (op_r)
            O_IDLE: if (start) begin
               op_r      <= O_CHECK;
               okind_r   <= kind_r;
               blk_r     <= sfirst;
               blk0_r    <= sfirst;
               blk_end_r <= sfirst | smask;
               hit_r     <= 1'b0;
               base_r    <= addr_r[AW-1:0];
            end
            O_CHECK: begin
               hit_r <= hit_r | blk_prot;
               blk_r <= chk_end ? blk0_r : blk_r + 13'h0001;
               idx_r <= '0;
               if (chk_fail) begin
                  op_r <= O_IDLE;
               end else if (chk_end) begin
                  op_r <= O_RUN;
               end
            end
            O_RUN: begin
               idx_r <= idx_r + 9'h001;
               blk_r <= blk_r + 13'h0001;
               if (run_end) begin
                  op_r  <= O_WAIT;
                  tmr_r <= (okind_r == K_PROG) ? TW'(PROG_CYCLES - 1) : TW'(ERASE_CYCLES - 1);
               end
            end
            O_WAIT: begin
               tmr_r <= tmr_r - 16'h0001;
               if (tmr_r == '0) begin
                  op_r <= O_IDLE;
               end
            end
         endcase
      end
   end

   // array strobes; overlaid blocks skipped by sector erase
   wire skip_ovl = (okind_r == K_SERASE) & b_ovl;
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pact_r <= 1'b0;
         pidx_r <= '0;
         arr_r  <= '0;
      end else begin
         pact_r      <= (op_r == O_RUN) && (okind_r == K_PROG);
         pidx_r      <= idx_r;
         arr_r.wr    <= pact_r & buf_rvalid;
         arr_r.erase <= (op_r == O_RUN) && (okind_r != K_PROG) && !skip_ovl;
         arr_r.addr  <= pact_r ? {base_r[AW-1:PIW], (base_r[PIW-1:0] & ~pmask) | pidx_r}
                               : {blk_r, {BLK_SH{1'b0}}};
         arr_r.data  <= buf_rdata;
      end
   end

   assign ARR    = arr_r;
   assign STATUS = '{write_in_progress: busy, write_enable_latch: wel_r, p_err: perr_r, e_err: eerr_r};

   // checks
   property p_wel_gate;
      @(posedge SYS_CLK) disable iff (!RSTN) (op_r == O_IDLE && start) |-> wel_r;
   endproperty
   a_wel_gate: assert property (p_wel_gate) else $error("operation started without latch");

   property p_alen;
      @(posedge SYS_CLK) disable iff (!RSTN) accept |=> (abytes_r == $past(alen)) && (frame_r == F_ADDR);
   endproperty
   a_alen: assert property (p_alen) else $error("wrong address length");

   property p_ptr_in_page;
      @(posedge SYS_CLK) disable iff (!RSTN) (frame_r == F_DATA) |-> ((ptr_r & ~pmask) == '0);
   endproperty
   a_ptr_in_page: assert property (p_ptr_in_page) else $error("page pointer left page");

   property p_wip_prog;
      @(posedge SYS_CLK) disable iff (!RSTN) (start_prog && !busy) |=> STATUS.write_in_progress [*8];
   endproperty
   a_wip_prog: assert property (p_wip_prog) else $error("busy flag dropped early");

   property p_perr;
      @(posedge SYS_CLK) disable iff (!RSTN) (chk_fail && okind_r == K_PROG) |=> perr_r && !STATUS.write_in_progress;
   endproperty
   a_perr: assert property (p_perr) else $error("program error not flagged");

   property p_uniform;
      @(posedge SYS_CLK) disable iff (!RSTN) (in_cmd && is_pe && CFG.uniform) |=> frame_r == F_SKIP;
   endproperty
   a_uniform: assert property (p_uniform) else $error("parameter erase not ignored");

   property p_discard;
      @(posedge SYS_CLK) disable iff (!RSTN)
         (rise_s.cs_n && frame_r == F_ADDR && abytes_r != 3'h0 && !busy) |=> op_r == O_IDLE;
   endproperty
   a_discard: assert property (p_discard) else $error("erase ran on early chip-select rise");

   property p_large_quiet;
      @(posedge SYS_CLK) disable iff (!RSTN)
         (start_erase && pe_large && !busy) |=> !$rose(eerr_r) && op_r == O_IDLE;
   endproperty
   a_large_quiet: assert property (p_large_quiet) else $error("large-sector parameter erase acted");

   property p_skip_ovl;
      @(posedge SYS_CLK) disable iff (!RSTN)
         (op_r == O_RUN && okind_r == K_SERASE && b_ovl) |=> !arr_r.erase;
   endproperty
   a_skip_ovl: assert property (p_skip_ovl) else $error("overlaid block erased");

   property p_wel_clear;
      @(posedge SYS_CLK) disable iff (!RSTN) op_done |=> !wel_r && !STATUS.write_in_progress;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch kept after operation");

   c_prog:  cover property (@(posedge SYS_CLK) disable iff (!RSTN) arr_r.wr);
   c_erase: cover property (@(posedge SYS_CLK) disable iff (!RSTN) arr_r.erase && okind_r == K_SERASE);
   c_eerr:  cover property (@(posedge SYS_CLK) disable iff (!RSTN) $rose(eerr_r));
endmodule : sfp_seq

//--- hdl/sfp_sync.sv
`timescale 1ns/10ps
module sfp_sync #(
   parameter int           W    = 6,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // raw pins and filtered view
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   genvar g;
   // three stages per pin; a change counts once stages two and three agree
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
         wire  lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r   <= INIT[g];
               s2_r   <= INIT[g];
               s3_r   <= INIT[g];
               lvl_r  <= INIT[g];
               rise_r <= 1'b0;
               fall_r <= 1'b0;
            end else begin
               s1_r   <= din[g];
               s2_r   <= s1_r;
               s3_r   <= s2_r;
               lvl_r  <= lvl_nxt;
               rise_r <= lvl_nxt & ~lvl_r;
               fall_r <= ~lvl_nxt & lvl_r;
            end
         end
         assign lvl[g]  = lvl_r;
         assign rise[g] = rise_r;
         assign fall[g] = fall_r;
      end
   endgenerate
endmodule : sfp_sync

//--- verification/sfp_host.sv
`timescale 1ns/10ps
module sfp_host
   import sfp_pkg::*;
(
   // serial pins toward the device
   output sfp_link_t LINK
);
   // sck stands low outside frames; io is flipped so no stale bit looks valid
   initial LINK = '{sck: 1'b0, cs_n: 1'b1, io: 4'hA};

   // one sck period, io set well ahead of the rise
   task automatic clk_out(input logic [3:0] v);
      LINK.io = v;
      #80 LINK.sck = 1'b1;
      #80 LINK.sck = 1'b0;
   endtask : clk_out

   // msb first; quad sends the high nibble first
   task automatic put_byte(input logic [7:0] b, input logic q);
      if (q) begin
         clk_out(b[7:4]);
         clk_out(b[3:0]);
      end else begin
         for (int i = 7; i >= 0; i--) clk_out({{3{~b[i]}}, b[i]});
      end
   endtask : put_byte

   // whole frame: instruction, na address bytes, nd data bytes counting up from d
   task automatic frame(input logic [7:0] c, input logic [31:0] a, input int na,
                        input int nd, input logic [7:0] d, input logic q);
      LINK.cs_n = 1'b0;
      #80;
      put_byte(c, q);
      for (int i = na - 1; i >= 0; i--) put_byte(a[8*i+:8], q);
      for (int i = 0; i < nd; i++) put_byte(d + 8'(i), q);
      #80 LINK.cs_n = 1'b1;
      LINK.io = ~LINK.io;
      #400;
   endtask : frame
endmodule : sfp_host

//--- verification/sfp_seq_test.sv
`timescale 1ns/10ps
module sfp_seq_test;
   import sfp_pkg::*;
   `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
   logic        SYS_CLK = 1'b0;
   logic        RSTN    = 1'b0;
   sfp_link_t   LINK;
   sfp_cfg_t    CFG     = '0;
   logic [2:0]  BP      = 3'h0;
   sfp_prot_t   PROT    = '0;
   logic        CLR_ERR = 1'b0;
   sfp_status_t STATUS;
   sfp_arr_t    ARR;
   int          fails, n_compared, nw, ne;
   logic        saw;
   logic [24:0] wa0, wa1, ea0;
   logic [7:0]  wd0;

   always #5 SYS_CLK = ~SYS_CLK;

   sfp_host u_host (.LINK(LINK));
   sfp_seq #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) u_dut (
      .SYS_CLK(SYS_CLK), .RSTN(RSTN), .LINK(LINK), .CFG(CFG), .BP(BP),
      .PROT(PROT), .CLR_ERR(CLR_ERR), .STATUS(STATUS), .ARR(ARR));

   // array port monitor: first and last write, first erase; falling edge, outputs settled
   always @(negedge SYS_CLK) begin
      if (STATUS.write_in_progress === 1'b1) saw = 1'b1;
      if (ARR.wr === 1'b1) begin
         if (nw == 0) {wa0, wd0} = {ARR.addr, ARR.data};
         wa1 = ARR.addr;
         nw++;
      end
      if (ARR.erase === 1'b1) begin
         if (ne == 0) ea0 = ARR.addr;
         ne++;
      end
   end

   task automatic end_of_test();
      if (fails == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // one frame, then bounded wait until the internal cycle is over
   task automatic op(input logic [7:0] c, input logic [31:0] a, input int na,
                     input int nd, input logic [7:0] d);
      nw = 0;
      ne = 0;
      saw = 1'b0;
      u_host.frame(c, a, na, nd, d, CFG.quad);
      for (int k = 0; STATUS.write_in_progress !== 1'b0; k++) begin
         if (k > 3000) begin
            fails++;
            end_of_test();
         end
         @(negedge SYS_CLK);
      end
   endtask : op

   task automatic write_enable_cmd();
      op(CMD_WRITE_ENABLE_CMD, 0, 0, 0, 0);
      `CHK(STATUS.write_enable_latch, 1'b1)
   endtask : write_enable_cmd

   // one protection entry, pulsed for a single cycle
   task automatic prot(input logic p, input int i, input logic pp, input logic dy);
      @(negedge SYS_CLK) PROT = '{wr: 1'b1, param: p, idx: 9'(i), persistent_protect_bit: pp, dynamic_protect_bit: dy};
      @(negedge SYS_CLK) PROT.wr = 1'b0;
   endtask : prot

   task automatic clr();
      @(negedge SYS_CLK) CLR_ERR = 1'b1;
      @(negedge SYS_CLK) CLR_ERR = 1'b0;
   endtask : clr

   initial begin
      repeat (10) @(negedge SYS_CLK);
      RSTN = 1'b1;
      repeat (5) @(negedge SYS_CLK);
      op(CMD_PROG, 'h100, 3, 1, 'h55);
      `CHK(nw, 0)
      `CHK(saw, 1'b0)
      write_enable_cmd();
      op(CMD_PROG, 'hFE, 3, 3, 'h10);
      `CHK({nw, wa0, wd0, wa1}, {32'd3, 25'h0, 8'h12, 25'hFF})
      `CHK({saw, STATUS.write_in_progress, STATUS.write_enable_latch}, 3'b100)
      CFG.quad = 1'b1;
      CFG.page512 = 1'b1;
      write_enable_cmd();
      op(CMD_PROG_W, 'h1FF, 4, 2, 'hA0);
      `CHK({nw, wa0, wd0, wa1}, {32'd2, 25'h0, 8'hA1, 25'h1FF})
      {CFG.quad, CFG.addr4} = 2'b01;
      write_enable_cmd();
      op(CMD_PROG, 'h300, 4, 1, 'h77);
      `CHK({nw, wa1}, {32'd1, 25'h300})
      {CFG.addr4, CFG.uniform} = 2'b01;
      write_enable_cmd();
      op(CMD_PERASE, 'h1000, 3, 0, 0);
      `CHK({ne, STATUS.write_enable_latch}, {32'd0, 1'b1})
      CFG.uniform = 1'b0;
      op(CMD_PERASE, 'h1000, 3, 0, 0);
      `CHK({ne, ea0}, {32'd1, 25'h1000})
      write_enable_cmd();
      op(CMD_SERASE, 0, 3, 0, 0);
      `CHK({ne, ea0}, {32'd8, 25'h8000})
      write_enable_cmd();
      op(CMD_SERASE_W, 'h20000, 4, 0, 0);
      `CHK({ne, ea0, saw, STATUS.write_in_progress}, {32'd16, 25'h20000, 2'b10})
      write_enable_cmd();
      op(CMD_SERASE, 'h30000, 3, 1, 0);
      `CHK(ne, 0)
      op(CMD_SERASE, 'h30000, 2, 0, 0);
      `CHK(ne, 0)
      op(CMD_PERASE, 'h50000, 3, 0, 0);
      `CHK({ne, STATUS.e_err}, {32'd0, 1'b0})
      prot(1'b0, 1, 1'b1, 1'b0);
      prot(1'b1, 2, 1'b0, 1'b1);
      CFG.sect256 = 1'b1;
      write_enable_cmd();
      op(CMD_SERASE, 0, 3, 0, 0);
      `CHK({ne, STATUS.e_err}, {32'd0, 1'b1})
      clr();
      CFG.sect256 = 1'b0;
      write_enable_cmd();
      op(CMD_PERASE, 'h2000, 3, 0, 0);
      `CHK({ne, STATUS.e_err}, {32'd0, 1'b1})
      clr();
      write_enable_cmd();
      op(CMD_SERASE, 'h10000, 3, 0, 0);
      `CHK({ne, STATUS.e_err}, {32'd0, 1'b1})
      clr();
      BP = 3'h7;
      write_enable_cmd();
      op(CMD_SERASE, 'h40000, 3, 0, 0);
      `CHK({ne, STATUS.e_err}, {32'd0, 1'b1})
      clr();
      BP = 3'h0;
      CFG.param_top = 1'b1;
      write_enable_cmd();
      op(CMD_PERASE_W, 'h1FFF000, 4, 0, 0);
      `CHK({ne, ea0}, {32'd1, 25'h1FFF000})
      CFG.param_top = 1'b0;
      write_enable_cmd();
      op(CMD_PROG, 'h10010, 3, 1, 'h00);
      `CHK({nw, STATUS.p_err, STATUS.write_enable_latch}, {32'd0, 2'b10})
      end_of_test();
   end
endmodule : sfp_seq_test
